// ---- rtl/hotplug_sequencer.sv ----
// Per-slot enable, breaker, thermal, retention and power-good sequencing
// for two hot-plug slots, with a small APB register window.
// Assumes analog comparators arrive as level events; one 250 MHz clock.
//
// The APB register port and the register offsets were chosen for this implementation.

// How it works
// - Main supply undervoltage while enabled raises faults
// - Aux rail follows only its enable, standby
// - Slow main overcurrent trips both main rails
// - Fast-trip threshold shuts main rails immediately
// - Undervoltage trips breaker only while mains on
// - Aux breaker trips only on timer expiry
// - Any trip raises matching fault and interrupt
// - Interrupt clears only on slot enable fall
// - Overload starts analog and 40 ms filters
// - Breaker trips on the shorter filter delay
// - Latch-off holds trip until enable toggles
// - Auto-retry restarts after 820 ms counter
// - Grounded filter pin uses digital delay only
// - 140C aux overload kills slot, aux fault
// - 160C kills both slots, both aux faults
// - Gates stay off unless retention switch low
// - Retention switch debounced for 10 ms
// - Force-on powers slot, drops all protections except standby UV on aux
// - Force-on asserts power-good, releases faults
// - Power-good needs enable and three live rails
// - Delayed power-good follows 164 ms later
// - Enables are active-high level inputs
module hotplug_sequencer
  import hotplug_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Controller pins, per slot
  input  wire logic [1:0]        main_enable_in,
  input  wire logic [1:0]        aux_enable_in,
  input  wire logic [1:0]        card_retention_sw_n,
  input  wire logic [1:0]        diag_force_on_n,
  // Analog events, per slot except die_hot_160 (shared)
  input  wire logic [1:0]        main_12v_input_uv,
  input  wire logic [1:0]        main_3v3_input_uv,
  input  wire logic [1:0]        standby_supply_uv,
  input  wire logic [1:0]        main_over_limit,
  input  wire logic [1:0]        main_fast_trip,
  input  wire logic [1:0]        aux_over_limit,
  input  wire logic [1:0]        fault_filter_cap_timeout,
  input  wire logic [1:0]        fault_filter_cap_pin_grounded,
  input  wire logic [1:0]        main_12v_good,
  input  wire logic [1:0]        main_3v3_good,
  input  wire logic [1:0]        aux_good,
  input  wire logic [1:0]        die_hot_140,
  input  wire logic              die_hot_160,
  // Rail drives and status pins
  output logic [1:0]             main_12v_gate_on,
  output logic [1:0]             main_3v3_gate_on,
  output logic [1:0]             aux_rail_out,
  output logic [1:0]             main_fault_n,
  output logic [1:0]             aux_fault_n,
  output logic [1:0]             slot_power_good_n,
  output logic [1:0]             delayed_power_good_n,
  output logic                   interrupt_n,
  output logic                   system_power_good
);

  localparam int SYNC_W = 33;
  // Idle pin levels: force-on and retention switch rest high
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {{(SYNC_W-8){1'b0}}, 4'hf, 4'h0};

  initial
  begin
    if (TICK_DIV < 2)
      $error("hotplug_sequencer: TICK_DIV must be at least 2");
  end

  // Input synchronisers
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  wire  [SYNC_W-1:0] raw_in = {die_hot_160, die_hot_140, aux_good, main_3v3_good,
                               main_12v_good, fault_filter_cap_pin_grounded,
                               fault_filter_cap_timeout, aux_over_limit,
                               main_fast_trip, main_over_limit, standby_supply_uv,
                               main_3v3_input_uv, main_12v_input_uv, diag_force_on_n,
                               card_retention_sw_n, aux_enable_in, main_enable_in};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end
    else
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  wire       s_h160;
  wire [1:0] s_h140;
  wire [1:0] s_aux_good;
  wire [1:0] s_3v3_good;
  wire [1:0] s_12v_good;
  wire [1:0] s_cap_gnd;
  wire [1:0] s_cap_to;
  wire [1:0] s_aux_oc;
  wire [1:0] s_fast;
  wire [1:0] s_main_oc;
  wire [1:0] s_stby_uv;
  wire [1:0] s_uv33;
  wire [1:0] s_uv12;
  wire [1:0] s_force_n;
  wire [1:0] s_crsw_n;
  wire [1:0] s_aux_en;
  wire [1:0] s_main_en;

  assign {s_h160, s_h140, s_aux_good, s_3v3_good, s_12v_good, s_cap_gnd, s_cap_to,
          s_aux_oc, s_fast, s_main_oc, s_stby_uv, s_uv33, s_uv12, s_force_n,
          s_crsw_n, s_aux_en, s_main_en} = sync2;

  // Common millisecond tick
  logic tick;

  tick_divider #(.DIV(TICK_DIV)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // Software control
  logic [31:0] ctrl;
  wire         auto_retry = ctrl[CTRL_RETRY_BIT];

  // Per-slot state seen by the status register and global outputs
  wire [1:0] main_fault;
  wire [1:0] aux_fault;
  wire [1:0] pg;
  wire [1:0] dly_pg;
  wire [1:0] crsw_open;
  wire [1:0] irq;
  wire [1:0] force_on;
  wire [1:0] slot_short;

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_slot
      logic crsw_deb;
      logic main_en_q;
      logic aux_en_q;
      logic main_trip;
      logic aux_trip;
      logic therm_off;
      logic main_flt;
      logic aux_flt;
      logic irq_q;
      logic main_on;
      logic aux_on;
      logic pg_q;
      logic deb_done;
      logic main_flt_done;
      logic aux_flt_done;
      logic retry_done;
      logic dpg_done;

      wire frc       = ~s_force_n[i];
      wire crsw_ok   = ~crsw_deb;
      wire main_fall = main_en_q & ~s_main_en[i];
      wire aux_fall  = aux_en_q & ~s_aux_en[i];
      wire main_uv   = s_uv12[i] | s_uv33[i];
      wire cap_trip  = ~s_cap_gnd[i] & s_cap_to[i];
      wire main_slow = main_flt_done | (s_main_oc[i] & main_on & cap_trip);
      wire aux_slow  = aux_flt_done | (s_aux_oc[i] & aux_on & cap_trip);
      wire main_ev   = ~frc & s_main_en[i]
                       & ((main_uv & main_on) | (s_fast[i] & main_on) | main_slow);
      wire uv_fault  = ~frc & s_main_en[i] & main_uv;
      wire aux_ev    = ~frc & s_aux_en[i] & aux_slow;
      wire hot_ev    = ~frc & ((s_h140[i] & s_aux_oc[i]) | s_h160);
      wire retry_go  = retry_done & auto_retry;
      wire next_main_on = frc | (s_main_en[i] & crsw_ok & ~main_uv & ~main_trip
                                 & ~therm_off & ~main_ev & ~hot_ev);
      wire next_aux_on  = ~s_stby_uv[i] & (frc | (s_aux_en[i] & crsw_ok & ~aux_trip
                                 & ~therm_off & ~aux_ev & ~hot_ev));
      wire next_pg      = frc | (s_main_en[i] & s_aux_en[i] & main_on & aux_on
                                 & s_12v_good[i] & s_3v3_good[i] & s_aux_good[i]);

      // Retention switch debounce
      ms_timer u_deb (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .run     (s_crsw_n[i] != crsw_deb),
        .limit   (DEBOUNCE_CNT),
        .done    (deb_done)
      );

      // Digital filters start with the overload
      ms_timer u_main_flt (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .run     (s_main_oc[i] & main_on & ~frc),
        .limit   (DIG_FILTER_CNT),
        .done    (main_flt_done)
      );

      ms_timer u_aux_flt (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .run     (s_aux_oc[i] & aux_on & ~frc),
        .limit   (DIG_FILTER_CNT),
        .done    (aux_flt_done)
      );

      // Cool-down before retry
      ms_timer u_retry (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .run     (auto_retry & (main_trip | aux_trip | therm_off)),
        .limit   (RETRY_CNT),
        .done    (retry_done)
      );

      // Delayed power-good
      ms_timer u_dpg (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .run     (pg_q),
        .limit   (PG_DELAY_CNT),
        .done    (dpg_done)
      );

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          crsw_deb  <= 1'b1;
          main_en_q <= 1'b0;
          aux_en_q  <= 1'b0;
          main_trip <= 1'b0;
          aux_trip  <= 1'b0;
          therm_off <= 1'b0;
          main_flt  <= 1'b0;
          aux_flt   <= 1'b0;
          irq_q     <= 1'b0;
          main_on   <= 1'b0;
          aux_on    <= 1'b0;
          pg_q      <= 1'b0;
        end
        else
        begin
          crsw_deb  <= deb_done ? s_crsw_n[i] : crsw_deb;
          main_en_q <= s_main_en[i];
          aux_en_q  <= s_aux_en[i];
          main_trip <= main_ev | (main_trip & ~main_fall & ~retry_go);
          aux_trip  <= aux_ev | (aux_trip & ~aux_fall & ~retry_go);
          therm_off <= hot_ev | (therm_off & ~aux_fall & ~retry_go);
          main_flt  <= main_ev | uv_fault | (main_flt & ~main_fall);
          aux_flt   <= aux_ev | hot_ev | (aux_flt & ~aux_fall);
          irq_q     <= main_ev | aux_ev | hot_ev | uv_fault
                       | (irq_q & ~main_fall & ~aux_fall);
          main_on   <= next_main_on;
          aux_on    <= next_aux_on;
          pg_q      <= next_pg;
        end
      end

      assign main_fault[i] = main_flt & ~frc;
      assign aux_fault[i]  = aux_flt & ~frc;
      assign pg[i]         = pg_q;
      assign dly_pg[i]     = frc | dpg_done;
      assign crsw_open[i]  = crsw_deb;
      assign irq[i]        = irq_q & ~frc;
      assign force_on[i]   = frc;
      assign slot_short[i] = (s_main_en[i] | s_aux_en[i]) & crsw_ok & ~frc
                             & ~(s_12v_good[i] & s_3v3_good[i] & s_aux_good[i]);
      assign main_12v_gate_on[i] = main_on;
      assign main_3v3_gate_on[i] = main_on;
      assign aux_rail_out[i]     = aux_on;
    end
  endgenerate

  // Status pins, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_fault_n         <= 2'h3;
      aux_fault_n          <= 2'h3;
      slot_power_good_n    <= 2'h3;
      delayed_power_good_n <= 2'h3;
      interrupt_n          <= 1'b1;
      system_power_good    <= 1'b1;
    end
    else
    begin
      main_fault_n         <= ~main_fault;
      aux_fault_n          <= ~aux_fault;
      slot_power_good_n    <= ~pg;
      delayed_power_good_n <= ~dly_pg;
      interrupt_n          <= ~|irq;
      system_power_good    <= (|force_on) | ~|slot_short;
    end
  end

  // APB slave: one wait state, then ready
  wire        access   = psel & penable & ~pready;
  wire        hit_ctrl = (paddr == CTRL_ADDR);
  wire        hit_stat = (paddr == STATUS_ADDR);
  wire        mapped   = hit_ctrl | hit_stat;
  wire [31:0] status   = {16'h0000, aux_rail_out, main_12v_gate_on, irq, crsw_open,
                          dly_pg, pg, aux_fault, main_fault};
  wire [31:0] rd_mux   = hit_ctrl ? ctrl : hit_stat ? status : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl    <= CTRL_RESET;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access;
      pslverr <= access & ~mapped;
      prdata  <= (access & ~pwrite) ? rd_mux : prdata;
      if (psel && penable && pready && pwrite && hit_ctrl)
        ctrl <= pwdata & 32'h0000_0001;
    end
  end

endmodule // hotplug_sequencer

// ---- rtl/hotplug_pkg.sv ----
// Constants shared by the dual-slot hot-plug fault sequencer.
// Assumes a single 250 MHz clock; millisecond timers count a 1 ms tick.
package hotplug_pkg;

  // Clock and tick
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  // Millisecond timers, in ticks
  localparam int       TMR_W          = 10;
  localparam int       DIG_FILTER_MS  = 40;
  localparam int       RETRY_MS       = 820;
  localparam int       DEBOUNCE_MS    = 10;
  localparam int       PG_DELAY_MS    = 164;
  localparam bit [9:0] DIG_FILTER_CNT = 10'(DIG_FILTER_MS);
  localparam bit [9:0] RETRY_CNT      = 10'(RETRY_MS);
  localparam bit [9:0] DEBOUNCE_CNT   = 10'(DEBOUNCE_MS);
  localparam bit [9:0] PG_DELAY_CNT   = 10'(PG_DELAY_MS);

  // APB register map
  localparam int        ADDR_W         = 8;
  localparam bit [7:0]  CTRL_ADDR      = 8'h00;
  localparam bit [7:0]  STATUS_ADDR    = 8'h04;
  localparam bit [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam int        CTRL_RETRY_BIT = 0;

  // Status field positions, two bits each (slot A low, slot B high)
  localparam int ST_MAIN_FAULT = 0;
  localparam int ST_AUX_FAULT  = 2;
  localparam int ST_PG         = 4;
  localparam int ST_DLY_PG     = 6;
  localparam int ST_CRSW_OPEN  = 8;
  localparam int ST_IRQ        = 10;
  localparam int ST_MAIN_ON    = 12;
  localparam int ST_AUX_ON     = 14;

endpackage

// ---- rtl/tick_divider.sv ----
// Divides the system clock into a one-cycle enable pulse.
// Assumes one clock and an asynchronous active-low reset.
module tick_divider
  import hotplug_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);

  localparam int CW = $clog2(DIV);

  initial
  begin
    if (DIV < 2)
      $error("tick_divider: DIV must be at least 2");
  end

  logic [CW-1:0] count;
  wire           wrap = (count == CW'(DIV - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= wrap ? '0 : count + CW'(1);
      tick  <= wrap;
    end
  end

endmodule // tick_divider

// ---- rtl/ms_timer.sv ----
// Tick counter that flags when a run has lasted the given number of ticks.
// Assumes tick is a one-cycle enable; dropping run clears the count.
module ms_timer
  import hotplug_pkg::*;
#(
  parameter int W = TMR_W
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  output logic              done
);

  initial
  begin
    if (W < 1)
      $error("ms_timer: W must be positive");
  end

  logic [W-1:0] count;
  wire          last = tick && (count == limit - W'(1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      done  <= 1'b0;
    end
    else
    begin
      count <= (!run) ? '0 : (tick && !done) ? count + W'(1) : count;
      done  <= run && (done || last);
    end
  end

endmodule // ms_timer

// ---- dv/hotplug_sequencer_asserts.sv ----
// Concurrent checks on the hot-plug sequencer pins, slot A unless noted.
// Assumes a bind into hotplug_sequencer with its TICK_DIV handed on.
module hotplug_sequencer_asserts
  import hotplug_pkg::*;
#(
  parameter int TICK_DIV = 4
)
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [1:0] main_enable_in,
  input wire logic [1:0] aux_enable_in,
  input wire logic [1:0] card_retention_sw_n,
  input wire logic [1:0] diag_force_on_n,
  input wire logic [1:0] main_over_limit,
  input wire logic [1:0] main_fast_trip,
  input wire logic [1:0] fault_filter_cap_pin_grounded,
  input wire logic       die_hot_160,
  input wire logic [1:0] main_12v_gate_on,
  input wire logic [1:0] aux_rail_out,
  input wire logic [1:0] main_fault_n,
  input wire logic [1:0] aux_fault_n,
  input wire logic [1:0] slot_power_good_n,
  input wire logic [1:0] delayed_power_good_n,
  input wire logic       interrupt_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TRIP_LO = (DIG_FILTER_MS - 1) * TICK_DIV;
  localparam int TRIP_HI = (DIG_FILTER_MS + 1) * TICK_DIV + 4;
  localparam int PG_LO   = (PG_DELAY_MS - 1) * TICK_DIV;
  localparam int PG_HI   = (PG_DELAY_MS + 1) * TICK_DIV + 4;
  logic [19:0] over_cnt;
  logic [19:0] pg_cnt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Cycles of overload and of slot power good
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      over_cnt <= '0;
      pg_cnt   <= '0;
    end
    else
    begin
      over_cnt <= main_over_limit[0] ? over_cnt + 20'h1 : '0;
      pg_cnt   <= (slot_power_good_n[0] || !diag_force_on_n[0]) ? '0 : pg_cnt + 20'h1;
    end
  end

  sequence force_held_s;
    !diag_force_on_n[0] [*4];
  endsequence
  sequence heat_held_s;
    die_hot_160 [*5];
  endsequence

  chk_trip_raises_irq: assert property ($fell(main_fault_n[0]) |-> !interrupt_n)
    else $error("fault without interrupt");
  chk_irq_release: assert property ($rose(interrupt_n) && &diag_force_on_n |->
    $past(main_enable_in, 3) != 2'b11 || $past(aux_enable_in, 3) != 2'b11)
    else $error("interrupt released without enable fall");
  chk_gate_switch: assert property ($rose(main_12v_gate_on[0]) && diag_force_on_n[0] |->
    !card_retention_sw_n[0] && !$past(card_retention_sw_n[0], 8))
    else $error("gate on with switch open");
  chk_trip_window: assert property ($fell(main_fault_n[0]) && main_over_limit[0] &&
    !main_fast_trip[0] && fault_filter_cap_pin_grounded[0] |->
    over_cnt >= TRIP_LO && over_cnt <= TRIP_HI)
    else $error("slow trip off its filter time");
  chk_fast_trip: assert property (main_fast_trip[0] && diag_force_on_n[0] &&
    main_12v_gate_on[0] |-> ##[1:4] !main_12v_gate_on[0])
    else $error("fast trip too slow");
  chk_dly_pg: assert property ($fell(delayed_power_good_n[0]) && diag_force_on_n[0] |->
    pg_cnt >= PG_LO && pg_cnt <= PG_HI)
    else $error("delayed power good off time");
  chk_heat_all_off: assert property (heat_held_s |-> diag_force_on_n != 2'b11 ||
    (aux_rail_out == 2'b00 && main_12v_gate_on == 2'b00))
    else $error("outputs on while die overheated");
  chk_force_outs: assert property (force_held_s |-> !slot_power_good_n[0] &&
    !delayed_power_good_n[0] && main_fault_n[0] && aux_fault_n[0])
    else $error("forced slot status wrong");
endmodule // hotplug_sequencer_asserts

// ---- dv/hotplug_ctrl_model.sv ----
// External hot-plug controller: slot enables, retention switches, force pins.
// Assumes one pclk; the bench may also steer these pins directly.
module hotplug_ctrl_model
(
  input  wire logic  pclk,
  output logic [1:0] main_enable_in      = 2'b11,
  output logic [1:0] aux_enable_in       = 2'b11,
  output logic [1:0] card_retention_sw_n = 2'b11,
  output logic [1:0] diag_force_on_n     = 2'b11
);
  timeunit 1ns;
  timeprecision 1ps;
  // Restart tripped rails: enable high-low-high on the chosen slots
  task automatic restart(input logic [1:0] m, input logic [1:0] a);
    @(posedge pclk);
    main_enable_in <= main_enable_in & ~m;
    aux_enable_in  <= aux_enable_in & ~a;
    repeat (8) @(posedge pclk);
    main_enable_in <= main_enable_in | m;
    aux_enable_in  <= aux_enable_in | a;
    repeat (8) @(posedge pclk);
  endtask
endmodule // hotplug_ctrl_model

// ---- dv/test_hotplug_sequencer.sv ----
// Self-checking bench for the hot-plug sequencer, slot A exercised.
// Assumes a shortened tick (TD cycles) so millisecond counts stay short.
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("wrong value %s expected %0h seen %0h", nm, e, g); \
    end \
  end
`define WAIT(c, n) \
  begin \
    k = 0; \
    while (!(c) && k < (n)) \
    begin \
      @(posedge pclk); \
      k++; \
    end \
    if (!(c)) \
    begin \
      n_errors++; \
      $display("wrong value wait timeout expected 1 seen 0"); \
    end \
  end
module test_hotplug_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import hotplug_pkg::*;
  localparam int TD = 4;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, interrupt_n, sys_pg, hot160 = 1'b0;
  logic [1:0]  m_en, a_en, sw_n, frc_n, g12, g3, aux_on, mf_n, af_n, pg_n, dpg_n;
  logic [1:0]  uv = 2'h0, over = 2'h0, fast = 2'h0, aover = 2'h0, hot = 2'h0;
  logic [1:0]  m12_good = 2'h0, agood = 2'h0;
  logic [1:0]  stby = 2'h0, cap_to = 2'h0, cap_gnd = 2'h3;
  int          n_errors = 0, tests_run = 0, k;

  always #2 pclk = ~pclk;

  hotplug_sequencer #(.TICK_DIV(TD)) hotplug_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_enable_in(m_en), .aux_enable_in(a_en), .card_retention_sw_n(sw_n),
    .diag_force_on_n(frc_n), .main_12v_input_uv(uv), .main_3v3_input_uv(2'b00),
    .standby_supply_uv(stby), .main_over_limit(over), .main_fast_trip(fast),
    .aux_over_limit(aover), .fault_filter_cap_timeout(cap_to),
    .fault_filter_cap_pin_grounded(cap_gnd), .main_12v_good(m12_good),
    .main_3v3_good(2'b11), .aux_good(agood), .die_hot_140(hot), .die_hot_160(hot160),
    .main_12v_gate_on(g12), .main_3v3_gate_on(g3), .aux_rail_out(aux_on),
    .main_fault_n(mf_n), .aux_fault_n(af_n), .slot_power_good_n(pg_n),
    .delayed_power_good_n(dpg_n), .interrupt_n(interrupt_n), .system_power_good(sys_pg));

  hotplug_ctrl_model hotplug_ctrl_model_inst (.pclk(pclk), .main_enable_in(m_en),
    .aux_enable_in(a_en), .card_retention_sw_n(sw_n), .diag_force_on_n(frc_n));

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset();
    #1;
    `CHK("gates", 4'h0, {g12, aux_on})
    `CHK("status pins", 5'h1f, {mf_n, af_n, interrupt_n})
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHK("status", 32'h0000_0300, rd)
    apb(1'b1, STATUS_ADDR, 32'hffff_ffff);
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHK("status ro", 32'h0000_0300, rd)
    apb(1'b0, CTRL_ADDR, 32'h0);
    `CHK("ctrl", CTRL_RESET, rd)
    apb(1'b0, 8'h08, 32'h0);
    `CHK("unmapped", 33'h0_0000_0000, {~err, rd})
  endtask

  task automatic t_power_up();
    @(posedge pclk);
    hotplug_ctrl_model_inst.card_retention_sw_n[0] <= 1'b0;
    `WAIT(g12[0] === 1'b1, 200)
    `CHK("debounce", 1'b1, k inside {[35:50]})
    #1;
    `CHK("aux on", 1'b1, aux_on[0])
    `CHK("pg early", 1'b1, pg_n[0])
    @(posedge pclk);
    m12_good <= 2'b11;
    agood <= 2'b11;
    `WAIT(pg_n[0] === 1'b0, 20)
    `WAIT(dpg_n[0] === 1'b0, 800)
    `CHK("dly pg", 1'b1, k inside {[648:662]})
  endtask

  task automatic t_slow_trip(input logic r);
    @(posedge pclk);
    over <= 2'b01;
    cap_to <= 2'b01;
    `WAIT(mf_n[0] === 1'b0, 300)
    `CHK("trip delay", 1'b1, k inside {[155:172]})
    #1;
    `CHK("mains off aux on", 3'b001, {g12[0], g3[0], aux_on[0]})
    `CHK("int", 1'b0, interrupt_n)
    @(posedge pclk);
    over <= 2'b00;
    cap_to <= 2'b00;
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHK("status", 32'h0000_4601, rd)
    if (r)
    begin
      `WAIT(g12[0] === 1'b1, 4000)
      `CHK("retry", 1'b1, k inside {[3250:3300]})
    end
    else
    begin
      repeat (400) @(posedge pclk);
      `CHK("latched", 1'b0, g12[0])
    end
    hotplug_ctrl_model_inst.restart(2'b01, 2'b00);
    #1;
    `CHK("clear", 2'b11, {mf_n[0], interrupt_n})
    `WAIT(g12[0] === 1'b1, 100)
    `CHK("restart", 1'b1, g12[0])
  endtask

  task automatic t_fast_uv();
    @(posedge pclk);
    fast <= 2'b01;
    `WAIT(g12[0] === 1'b0, 20)
    `CHK("fast trip", 1'b1, k <= 4)
    fast <= 2'b00;
    hotplug_ctrl_model_inst.restart(2'b01, 2'b00);
    uv <= 2'b01;
    `WAIT(mf_n[0] === 1'b0, 20)
    #1;
    `CHK("uv fault", 2'b00, {interrupt_n, g12[0]})
    `CHK("aux in uv", 1'b1, aux_on[0])
    @(posedge pclk);
    hotplug_ctrl_model_inst.main_enable_in[0] <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHK("uv idle", 2'b11, {mf_n[0], interrupt_n})
    uv <= 2'b00;
    hotplug_ctrl_model_inst.main_enable_in[0] <= 1'b1;
    `WAIT(g12[0] === 1'b1, 100)
  endtask

  task automatic t_cap_pin();
    @(posedge pclk);
    cap_gnd <= 2'b10;
    cap_to <= 2'b01;
    over <= 2'b01;
    `WAIT(mf_n[0] === 1'b0, 20)
    `CHK("cap trip", 1'b1, k inside {[4:6]})
    over <= 2'b00;
    cap_to <= 2'b00;
    cap_gnd <= 2'b11;
    hotplug_ctrl_model_inst.restart(2'b01, 2'b00);
  endtask

  task automatic t_heat();
    @(posedge pclk);
    aover <= 2'b01;
    hot <= 2'b01;
    `WAIT(af_n[0] === 1'b0, 300)
    #1;
    `CHK("heat slot", 4'b0011, {g12[0], aux_on[0], mf_n[0], af_n[1]})
    @(posedge pclk);
    hot <= 2'b00;
    aover <= 2'b00;
    hotplug_ctrl_model_inst.restart(2'b01, 2'b01);
    `WAIT(aux_on[0] === 1'b1 && g12[0] === 1'b1, 100)
    aover <= 2'b01;
    `WAIT(af_n[0] === 1'b0, 300)
    `CHK("aux timer", 1'b1, k inside {[155:172]})
    `CHK("mains kept", 1'b1, g12[0])
    aover <= 2'b00;
    hot160 <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("heat all", 8'h03, {aux_on, g12, af_n, mf_n})
    hot160 <= 1'b0;
    hotplug_ctrl_model_inst.restart(2'b11, 2'b11);
    `WAIT(g12[0] === 1'b1 && aux_on[0] === 1'b1, 100)
  endtask

  task automatic t_force();
    @(posedge pclk);
    hotplug_ctrl_model_inst.diag_force_on_n[0] <= 1'b0;
    over <= 2'b01;
    repeat (300) @(posedge pclk);
    `CHK("forced on", 3'b111, {g12[0], aux_on[0], sys_pg})
    `CHK("forced pins", 4'b0011, {pg_n[0], dpg_n[0], mf_n[0], af_n[0]})
    over <= 2'b00;
    stby <= 2'b01;
    repeat (8) @(posedge pclk);
    `CHK("stby uvlo", 1'b0, aux_on[0])
    stby <= 2'b00;
    hotplug_ctrl_model_inst.diag_force_on_n[0] <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_power_up();
    t_slow_trip(1'b0);
    t_fast_uv();
    t_cap_pin();
    t_heat();
    t_force();
    apb(1'b1, CTRL_ADDR, 32'h1);
    t_slow_trip(1'b1);
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end
endmodule // test_hotplug_sequencer

bind hotplug_sequencer hotplug_sequencer_asserts #(.TICK_DIV(TICK_DIV)) asserts_inst (
  .pclk(pclk), .presetn(presetn), .main_enable_in(main_enable_in),
  .aux_enable_in(aux_enable_in), .card_retention_sw_n(card_retention_sw_n),
  .diag_force_on_n(diag_force_on_n), .main_over_limit(main_over_limit),
  .main_fast_trip(main_fast_trip), .fault_filter_cap_pin_grounded(fault_filter_cap_pin_grounded),
  .die_hot_160(die_hot_160), .main_12v_gate_on(main_12v_gate_on), .aux_rail_out(aux_rail_out),
  .main_fault_n(main_fault_n), .aux_fault_n(aux_fault_n), .slot_power_good_n(slot_power_good_n),
  .delayed_power_good_n(delayed_power_good_n), .interrupt_n(interrupt_n));
